// ### hw/epm_pkg.sv
package epm_pkg;
    // byte addresses on the register bus
    localparam logic [31:0] ADR_PORT_CTRL   = 32'h0010_4044;
    localparam logic [31:0] ADR_RGMII_STAT  = 32'h0c00_0030;
    localparam logic [31:0] ADR_SGMII_CTRL  = 32'h0c00_0100;
    localparam logic [31:0] ADR_SGMII_STAT  = 32'h0c00_0104;
    localparam logic [31:0] ADR_LOCAL_ABIL  = 32'h0c00_0108;
    localparam logic [31:0] ADR_PARTNER_ABL = 32'h0c00_010c;
    localparam logic [31:0] ADR_IRQ_STAT    = 32'h0c00_0110;
    localparam logic [31:0] ADR_IRQ_MASK    = 32'h0c00_0114;
    // port interface control
    localparam int          PMODE_LSB       = 0;
    localparam int          TXDLY_BIT       = 4;
    localparam logic [2:0]  MODE_RGMII      = 3'h2;
    localparam logic [2:0]  MODE_SGMII      = 3'h3;
    localparam logic [2:0]  PMODE_RST       = MODE_RGMII;
    // rgmii status
    localparam int          RG_LINK_BIT     = 0;
    localparam int          RG_SPD_LSB      = 1;
    localparam int          RG_DUP_BIT      = 3;
    // sgmii control
    localparam int          AN_EN_BIT       = 0;
    localparam int          FIBER_BIT       = 1;
    localparam int          NP_LOADED_BIT   = 3;
    localparam int          LEAD_BIT        = 5;
    localparam int          TEST_BIT        = 6;
    localparam logic [6:0]  SCTRL_RST       = 7'h01;
    // sgmii status
    localparam int          SS_LINK_BIT     = 0;
    localparam int          SS_FAULT_BIT    = 1;
    localparam int          SS_DONE_BIT     = 2;
    localparam int          SS_PAGE_BIT     = 3;
    localparam int          SS_LOCK_BIT     = 4;
    localparam int          SS_SIG_BIT      = 5;
    // ability word layout
    localparam int          AB_LINK_BIT     = 15;
    localparam int          AB_NP_BIT       = 15;
    localparam int          AB_DUP_BIT      = 12;
    localparam int          AB_SPD_LSB      = 10;
    localparam int          AB_FIB_FD_BIT   = 5;
    localparam logic [1:0]  SPD_1000        = 2'h2;
    localparam logic [15:0] LOCAL_ABIL_RST  = 16'h9801;
    // interrupt sources
    localparam int          IRQ_W           = 5;
    localparam int          IRQ_RG_LINK     = 0;
    localparam int          IRQ_SG_LINK     = 1;
    localparam int          IRQ_PAGE        = 2;
    localparam int          IRQ_DONE        = 3;
    localparam int          IRQ_FAULT       = 4;
    // K28.5 in both running disparities
    localparam logic [9:0]  K285_RDN        = 10'h0fa;
    localparam logic [9:0]  K285_RDP        = 10'h305;
    localparam int          SYNC_W          = 8;

    typedef enum logic [3:0] {
        AN_IDLE = 4'b0001,
        AN_ABIL = 4'b0010,
        AN_NEXT = 4'b0100,
        AN_DONE = 4'b1000
    } epm_an_t;
endpackage

// ### hw/epm_port_regs.sv
// Design decision made here: the Wishbone slave port.
`timescale 1ns/100ps
module epm_port_regs
    import epm_pkg::*;
#(
    parameter int ADDR_W = 32
) (
    // system
    input  wire logic              i_clk_sys,
    input  wire logic              i_reset,
    // wishbone slave
    input  wire logic              i_wb_cyc,
    input  wire logic              i_wb_stb,
    input  wire logic              i_wb_we,
    input  wire logic [ADDR_W-1:0] i_wb_adr,
    input  wire logic [3:0]        i_wb_sel,
    input  wire logic [31:0]       i_wb_dat,
    output logic      [31:0]       o_wb_dat,
    output logic                   o_wb_ack,
    // rgmii receive side, asynchronous
    input  wire logic              i_rgmii_rxc,
    input  wire logic              i_rgmii_rx_ctl,
    input  wire logic [3:0]        i_rgmii_rxd,
    // serdes pins, asynchronous
    input  wire logic              i_pll_lock,
    input  wire logic              i_optical_signal_present,
    // pcs ability words, same clock
    input  wire logic              i_an_word_valid,
    input  wire logic [15:0]       i_an_word,
    // encoder path
    input  wire logic [9:0]        i_tx_code,
    output logic      [9:0]        o_tx_code,
    // port configuration
    output logic      [2:0]        o_port_mode,
    output logic                   o_tx_delay_select,
    output logic      [1:0]        o_sgmii_speed,
    output logic                   o_sgmii_duplex,
    output logic                   o_irq
);

    if (ADDR_W != 32) begin : g_chk
        $error("epm_port_regs: ADDR_W must be 32");
    end

    // ---------------- bus decode ----------------
    logic              ack_r;
    logic [31:0]       rdat_r;
    wire               bus_hit   = i_wb_cyc & i_wb_stb & ~ack_r;
    // a write lands at the edge that samples ack, the one the master counts as done
    wire               wr_en     = i_wb_cyc & i_wb_stb & ack_r & i_wb_we & i_wb_sel[0];
    wire [31:0]        adr       = i_wb_adr;
    wire               sel_pctl  = adr == ADR_PORT_CTRL;
    wire               sel_rgst  = adr == ADR_RGMII_STAT;
    wire               sel_sctl  = adr == ADR_SGMII_CTRL;
    wire               sel_sst   = adr == ADR_SGMII_STAT;
    wire               sel_labl  = adr == ADR_LOCAL_ABIL;
    wire               sel_pabl  = adr == ADR_PARTNER_ABL;
    wire               sel_ist   = adr == ADR_IRQ_STAT;
    wire               sel_imsk  = adr == ADR_IRQ_MASK;
    wire               wr_pctl   = wr_en & sel_pctl;
    wire               wr_sctl   = wr_en & sel_sctl;
    wire               wr_labl   = wr_en & sel_labl & i_wb_sel[1];
    wire               wr_ist    = wr_en & sel_ist;
    wire               wr_imsk   = wr_en & sel_imsk;

    // ---------------- control registers ----------------
    logic [2:0]        pmode_r;
    logic              txdly_r;
    logic [6:0]        sctrl_r;
    logic [15:0]       local_r;
    logic [IRQ_W-1:0]  imask_r;

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            pmode_r <= PMODE_RST;
            txdly_r <= 1'b0;
            sctrl_r <= SCTRL_RST;
            local_r <= LOCAL_ABIL_RST;
            imask_r <= '0;
        end else begin
            if (wr_pctl) begin
                pmode_r <= i_wb_dat[PMODE_LSB +: 3];
                txdly_r <= i_wb_dat[TXDLY_BIT];
            end
            // np_loaded is an action bit and is never stored
            if (wr_sctl) begin
                sctrl_r <= i_wb_dat[6:0] & ~(7'h01 << NP_LOADED_BIT);
            end
            if (wr_labl) begin
                local_r <= i_wb_dat[15:0];
            end
            if (wr_imsk) begin
                imask_r <= i_wb_dat[IRQ_W-1:0];
            end
        end
    end

    wire               an_en     = sctrl_r[AN_EN_BIT];
    wire               fiber     = sctrl_r[FIBER_BIT];
    wire               lead      = sctrl_r[LEAD_BIT];
    wire               test_en   = sctrl_r[TEST_BIT];
    wire               np_clr    = wr_sctl & i_wb_dat[NP_LOADED_BIT];

    // ---------------- synchronisers ----------------
    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    wire  [SYNC_W-1:0] pins = {i_rgmii_rxc, i_rgmii_rx_ctl, i_rgmii_rxd,
                               i_optical_signal_present, i_pll_lock};

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
        end
    end

    wire               lock_s    = sync2_r[0];
    wire               sig_s     = sync2_r[1];
    wire  [3:0]        rxd_s     = sync2_r[5:2];
    wire               ctl_s     = sync2_r[6];
    wire               rxc_s     = sync2_r[7];

    // ---------------- rgmii in-band status ----------------
    // rxc is slow against the system clock, so data synchronised in the
    // same stage is settled at the detected rising edge
    logic              rxc_d_r;
    logic [3:0]        rgst_r;
    wire               rxc_rise  = rxc_s & ~rxc_d_r;
    wire               rg_upd    = rxc_rise & ~ctl_s;

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            rxc_d_r <= 1'b0;
            rgst_r  <= 4'h0;
        end else begin
            rxc_d_r <= rxc_s;
            if (rg_upd) begin
                rgst_r <= rxd_s;
            end
        end
    end

    // ---------------- auto-negotiation ----------------
    epm_an_t           an_st_r;
    epm_an_t           an_st_nxt;
    logic [15:0]       partner_r;
    logic              page_r;
    logic              fault_r;
    logic              link_r;
    wire               np_bit    = fiber & i_an_word[AB_NP_BIT];
    wire               an_run    = lock_s & an_en;
    wire               page_set  = an_run & (an_st_r == AN_NEXT) & i_an_word_valid;
    wire               an_done   = an_st_r == AN_DONE;

    always_comb begin
        an_st_nxt = an_st_r;
        unique case (an_st_r)
            AN_IDLE: begin
                an_st_nxt = AN_ABIL;
            end
            AN_ABIL: begin
                if (i_an_word_valid) begin
                    an_st_nxt = np_bit ? AN_NEXT : AN_DONE;
                end
            end
            AN_NEXT: begin
                if (i_an_word_valid && !np_bit) begin
                    an_st_nxt = AN_DONE;
                end
            end
            AN_DONE: begin
                an_st_nxt = AN_DONE;
            end
            default: begin
                an_st_nxt = AN_IDLE;
            end
        endcase
        if (!an_run) begin
            an_st_nxt = AN_IDLE;
        end
    end

    wire [15:0]        src_abil  = lead ? local_r : partner_r;
    wire [1:0]         res_spd   = src_abil[AB_SPD_LSB +: 2];
    wire               res_dup   = src_abil[AB_DUP_BIT];
    wire               sg_mode   = pmode_r == MODE_SGMII;
    wire               fault_sg  = sg_mode & ~fiber & an_done
                                   & (res_spd == SPD_1000) & ~res_dup;
    wire               fault_fb  = fiber & an_done
                                   & ~(local_r[AB_FIB_FD_BIT] & partner_r[AB_FIB_FD_BIT]);
    wire               link_an   = an_done & ~fault_r & (fiber | src_abil[AB_LINK_BIT]);
    // a forced link without negotiation only needs lock and light
    wire               link_nxt  = lock_s & (an_en ? link_an : sig_s);

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            an_st_r   <= AN_IDLE;
            partner_r <= '0;
            page_r    <= 1'b0;
            fault_r   <= 1'b0;
            link_r    <= 1'b0;
        end else begin
            an_st_r <= an_st_nxt;
            if (an_run && i_an_word_valid && (an_st_r == AN_ABIL)) begin
                partner_r <= i_an_word;
            end
            // a page arriving with the acknowledge write still counts
            page_r  <= page_set | (page_r & ~np_clr);
            fault_r <= fault_sg | fault_fb;
            link_r  <= link_nxt;
        end
    end

    // ---------------- encoder ----------------
    logic              disp_r;
    logic [9:0]        tx_r;

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            disp_r <= 1'b0;
            tx_r   <= 10'h000;
        end else begin
            disp_r <= test_en & ~disp_r;
            tx_r   <= test_en ? (disp_r ? K285_RDP : K285_RDN) : i_tx_code;
        end
    end

    // ---------------- interrupts ----------------
    logic [IRQ_W-1:0]  ist_r;
    logic              rg_link_d_r;
    logic              sg_link_d_r;
    logic              done_d_r;
    logic              fault_d_r;
    wire  [IRQ_W-1:0]  ev;
    assign ev[IRQ_RG_LINK] = rgst_r[RG_LINK_BIT] ^ rg_link_d_r;
    assign ev[IRQ_SG_LINK] = link_r ^ sg_link_d_r;
    assign ev[IRQ_PAGE]    = page_set;
    assign ev[IRQ_DONE]    = an_done & ~done_d_r;
    assign ev[IRQ_FAULT]   = fault_r & ~fault_d_r;
    wire  [IRQ_W-1:0]  ist_clr = wr_ist ? i_wb_dat[IRQ_W-1:0] : '0;

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            ist_r       <= '0;
            rg_link_d_r <= 1'b0;
            sg_link_d_r <= 1'b0;
            done_d_r    <= 1'b0;
            fault_d_r   <= 1'b0;
        end else begin
            ist_r       <= ev | (ist_r & ~ist_clr);
            rg_link_d_r <= rgst_r[RG_LINK_BIT];
            sg_link_d_r <= link_r;
            done_d_r    <= an_done;
            fault_d_r   <= fault_r;
        end
    end

    // ---------------- read back ----------------
    wire  [5:0]        sgst = {sig_s, lock_s, page_r, an_done, fault_r, link_r};
    // status words are live views, reading never disturbs them
    wire  [31:0]       rd_mux =
        sel_pctl ? {27'h0, txdly_r, 1'b0, pmode_r} :
        sel_rgst ? {28'h0, rgst_r} :
        sel_sctl ? {25'h0, sctrl_r} :
        sel_sst  ? {26'h0, sgst} :
        sel_labl ? {16'h0, local_r} :
        sel_pabl ? {16'h0, partner_r} :
        sel_ist  ? {{(32-IRQ_W){1'b0}}, ist_r} :
        sel_imsk ? {{(32-IRQ_W){1'b0}}, imask_r} : 32'h0;

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            ack_r  <= 1'b0;
            rdat_r <= 32'h0;
        end else begin
            ack_r  <= bus_hit;
            rdat_r <= bus_hit ? rd_mux : 32'h0;
        end
    end

    assign o_wb_ack          = ack_r;
    assign o_wb_dat          = rdat_r;
    assign o_tx_code         = tx_r;
    assign o_port_mode       = pmode_r;
    assign o_tx_delay_select = txdly_r;
    assign o_sgmii_speed     = res_spd;
    assign o_sgmii_duplex    = res_dup;
    assign o_irq             = |(ist_r & imask_r);

    // ---------------- checks ----------------
    a_mode_reset: assert property (@(posedge i_clk_sys) $fell(i_reset) |-> o_port_mode == MODE_RGMII)
        else $error("port mode not rgmii after reset");
    a_mode_write: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        wr_pctl |=> o_port_mode == $past(i_wb_dat[2:0]))
        else $error("port mode write lost");
    a_txdly_write: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        wr_pctl |=> o_tx_delay_select == $past(i_wb_dat[TXDLY_BIT]))
        else $error("tx delay write lost");
    a_rgmii_latch: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        rg_upd |=> rgst_r == $past(i_rgmii_rxd, 3))
        else $error("rgmii status not captured");
    a_rgmii_ro: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (wr_en && sel_rgst && !rg_upd) |=> $stable(rgst_r))
        else $error("rgmii status changed by write");
    a_test_alt: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        test_en [*3] |-> (o_tx_code == K285_RDN || o_tx_code == K285_RDP) && o_tx_code != $past(o_tx_code))
        else $error("k28.5 pattern not sent");
    a_lead_src: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        lead |-> o_sgmii_speed == local_r[AB_SPD_LSB +: 2] && o_sgmii_duplex == local_r[AB_DUP_BIT])
        else $error("lead side not using local ability");
    a_lock_mirror: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        !$past(i_reset) && !$past(i_reset, 2) |-> sgst[SS_LOCK_BIT] == $past(i_pll_lock, 2))
        else $error("lock bit not mirrored");
    a_page_set: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        page_set |=> page_r)
        else $error("next page flag not set");
    a_page_clear: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (np_clr && !page_set) |=> !page_r)
        else $error("next page flag not cleared");
    a_sg_fault: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (sg_mode && !fiber && an_done && res_spd == SPD_1000 && !res_dup) |=> fault_r)
        else $error("half duplex gigabit fault missed");
    a_link_lock: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        !lock_s |=> !link_r)
        else $error("sgmii link up without lock");
    a_sig_mirror: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        !$past(i_reset) && !$past(i_reset, 2) |-> sgst[SS_SIG_BIT] == $past(i_optical_signal_present, 2))
        else $error("signal detect not mirrored");
    a_done_flag: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (an_run && an_st_r == AN_ABIL && i_an_word_valid && !np_bit) |=> sgst[SS_DONE_BIT])
        else $error("negotiation done not shown");
    a_fiber_fault: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (fiber && an_done && !(local_r[AB_FIB_FD_BIT] && partner_r[AB_FIB_FD_BIT])) |=> fault_r)
        else $error("fiber duplex fault missed");
    a_sg_link: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (lock_s && an_en && an_done && !fault_r && (fiber || src_abil[AB_LINK_BIT])) |=> link_r)
        else $error("sgmii link not raised");
    a_rgmii_ignore: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (rxc_rise && ctl_s) |=> $stable(rgst_r))
        else $error("rgmii status taken inside frame");
    a_np_action: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        wr_sctl |=> !sctrl_r[NP_LOADED_BIT])
        else $error("next page loaded bit stored");
    a_enc_pass: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        !test_en |=> o_tx_code == $past(i_tx_code))
        else $error("encoder path not passed through");
    a_mode_hold: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        !wr_pctl |=> $stable(o_port_mode))
        else $error("port mode changed without write");

endmodule

// ### testbench/epm_partner_mac.sv
`timescale 1ns/100ps
module epm_partner_mac (
    // commands from the bench
    input  wire logic        i_clk_sys,
    input  wire logic        i_send_status,
    input  wire logic        i_in_frame,
    input  wire logic [3:0]  i_status,
    input  wire logic        i_send_word,
    input  wire logic [15:0] i_word,
    // toward the port
    output logic             o_rgmii_rxc,
    output logic             o_rgmii_rx_ctl,
    output logic [3:0]       o_rgmii_rxd,
    output logic             o_busy,
    output logic             o_an_word_valid,
    output logic [15:0]      o_an_word
);
    logic [3:0] st;

    // rxc only runs during a burst; it starts 1 ns after the command edge, so it never meets a system clock edge
    initial begin
        o_rgmii_rxc = 1'b0;
        o_rgmii_rx_ctl = 1'b0;
        o_rgmii_rxd = 4'h0;
        o_busy = 1'b0;
        #37;
        forever begin
            @(posedge i_clk_sys iff i_send_status);
            #1;
            o_busy = 1'b1;
            st = i_status;
            o_rgmii_rx_ctl = i_in_frame;
            o_rgmii_rxd = st;
            repeat (4) begin
                #80 o_rgmii_rxc = 1'b1;
                #80 o_rgmii_rxc = 1'b0;
            end
            // hold time over: data no longer shows the last value
            o_rgmii_rxd = ~st;
            o_rgmii_rx_ctl = 1'b0;
            o_busy = 1'b0;
        end
    end

    // this end stays follower, so lead is set on the port under test only
    initial begin
        o_an_word_valid = 1'b0;
        o_an_word = 16'h0;
        forever begin
            @(posedge i_clk_sys);
            o_an_word_valid <= i_send_word;
            o_an_word <= i_send_word ? i_word : ~o_an_word;
        end
    end
endmodule

// ### testbench/tb.sv
`timescale 1ns/100ps
module tb;
    import epm_pkg::*;
    typedef struct packed {logic [31:0] val; logic [31:0] msk;} epm_exp_t;
    logic        i_clk_sys, i_reset, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack;
    logic [31:0] i_wb_adr, i_wb_dat, o_wb_dat, seed;
    logic [3:0]  i_wb_sel, rxd, st;
    logic        rxc, rx_ctl, busy, an_valid, send_st, in_frame, send_w;
    logic        i_pll_lock, i_optical_signal_present, o_tx_delay_select, o_sgmii_duplex, o_irq;
    logic [15:0] an_word, word;
    logic [9:0]  i_tx_code, o_tx_code;
    logic [2:0]  o_port_mode;
    logic [1:0]  o_sgmii_speed;
    int          n_mismatch, samples_checked;
    epm_exp_t    expq[$];
    epm_exp_t    mon_e;

    epm_port_regs u_dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
        .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat),
        .o_wb_ack(o_wb_ack), .i_rgmii_rxc(rxc), .i_rgmii_rx_ctl(rx_ctl), .i_rgmii_rxd(rxd),
        .i_pll_lock(i_pll_lock), .i_optical_signal_present(i_optical_signal_present),
        .i_an_word_valid(an_valid), .i_an_word(an_word), .i_tx_code(i_tx_code), .o_tx_code(o_tx_code),
        .o_port_mode(o_port_mode), .o_tx_delay_select(o_tx_delay_select), .o_sgmii_speed(o_sgmii_speed),
        .o_sgmii_duplex(o_sgmii_duplex), .o_irq(o_irq));
    epm_partner_mac u_far (.i_clk_sys(i_clk_sys), .i_send_status(send_st), .i_in_frame(in_frame),
        .i_status(st), .i_send_word(send_w), .i_word(word), .o_rgmii_rxc(rxc), .o_rgmii_rx_ctl(rx_ctl),
        .o_rgmii_rxd(rxd), .o_busy(busy), .o_an_word_valid(an_valid), .o_an_word(an_word));

    initial begin
        i_clk_sys = 1'b0;
        forever #2 i_clk_sys = ~i_clk_sys;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic fail(input string m);
        n_mismatch++;
        $display("wrong value at %0t: %s", $time, m);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp) fail(m);
    endtask
    task automatic bus(input logic we, input logic [31:0] adr, input logic [31:0] dat, input logic [3:0] sel,
                       input epm_exp_t e);
        int n;
        expq.push_back(e);
        @(posedge i_clk_sys);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we <= we;
        i_wb_adr <= adr;
        i_wb_dat <= dat;
        i_wb_sel <= sel;
        for (n = 0; n < 50; n++) begin
            @(posedge i_clk_sys);
            if (o_wb_ack === 1'b1) break;
        end
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
        i_wb_we <= 1'b0;
        // the write lands at the ack edge; let it settle before the caller looks
        @(posedge i_clk_sys);
        if (n == 50) begin
            fail("no ack");
            results();
        end
    endtask
    task automatic wr(input logic [31:0] adr, input logic [31:0] dat);
        bus(1'b1, adr, dat, 4'hf, '{32'h0, 32'h0});
    endtask
    task automatic rd(input logic [31:0] adr, input logic [31:0] exp, input logic [31:0] msk);
        bus(1'b0, adr, 32'h0, 4'hf, '{exp, msk});
    endtask
    task automatic rg(input logic [3:0] s, input logic f);
        int n;
        @(posedge i_clk_sys);
        st <= s;
        in_frame <= f;
        send_st <= 1'b1;
        @(posedge i_clk_sys);
        send_st <= 1'b0;
        for (n = 0; n < 400; n++) begin
            @(posedge i_clk_sys);
            if (!busy) break;
        end
        repeat (8) @(posedge i_clk_sys);
        if (n == 400) begin
            fail("partner stuck");
            results();
        end
    endtask
    task automatic an(input logic [15:0] w);
        @(posedge i_clk_sys);
        word <= w;
        send_w <= 1'b1;
        @(posedge i_clk_sys);
        send_w <= 1'b0;
        repeat (6) @(posedge i_clk_sys);
    endtask

    // every ack retires the oldest note; write notes carry an empty mask
    always @(posedge i_clk_sys) begin
        if (o_wb_ack === 1'b1) begin
            if (expq.size() == 0) begin
                fail("ack without request");
            end else begin
                mon_e = expq.pop_front();
                if (mon_e.msk != 32'h0) begin
                    samples_checked++;
                    if ((o_wb_dat & mon_e.msk) !== mon_e.val) fail("read data");
                end
            end
        end
    end

    initial begin
        int          i;
        logic [31:0] v, ex;
        logic [9:0]  c;
        logic [9:0]  h[8];
        logic [3:0]  s;
        seed = 32'd93;
        n_mismatch = 0;
        samples_checked = 0;
        {i_reset, i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat, i_wb_sel} = {1'b1, 3'h0, 64'h0, 4'h0};
        {i_pll_lock, i_optical_signal_present, i_tx_code, send_st, in_frame, st, send_w, word} = '0;
        repeat (3) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        rd(ADR_PORT_CTRL, 32'h2, 32'hffff_ffff);
        rd(ADR_RGMII_STAT, 32'h0, 32'hf);
        rd(ADR_SGMII_CTRL, 32'h1, 32'h7f);
        rd(ADR_SGMII_STAT, 32'h0, 32'h3f);
        chk(o_tx_delay_select, 1'b0, "delay reset");
        $display("test done: reset values");
        for (i = 0; i < 8; i++) begin
            v = xs();
            wr(ADR_PORT_CTRL, {v[31:3], i[2:0]});
            ex = {27'h0, v[4], 1'b0, i[2:0]};
            rd(ADR_PORT_CTRL, ex, 32'hffff_ffff);
            chk(o_port_mode, i[2:0], "mode out");
            chk(o_tx_delay_select, v[4], "delay out");
        end
        bus(1'b1, ADR_PORT_CTRL, 32'h3, 4'h0, '{32'h0, 32'h0});
        rd(ADR_PORT_CTRL, ex, 32'hffff_ffff);
        wr(ADR_RGMII_STAT, 32'hffff_ffff);
        rd(ADR_RGMII_STAT, 32'h0, 32'hffff_ffff);
        wr(32'h0c00_0200, 32'hffff_ffff);
        rd(32'h0c00_0200, 32'h0, 32'hffff_ffff);
        $display("test done: control fields");
        rg(4'hd, 1'b0);
        rd(ADR_RGMII_STAT, 32'hd, 32'hffff_ffff);
        chk(o_irq, 1'b0, "masked irq");
        rd(ADR_IRQ_STAT, 32'h1, 32'h1);
        wr(ADR_IRQ_MASK, 32'h1);
        chk(o_irq, 1'b1, "irq raised");
        wr(ADR_IRQ_STAT, 32'h1);
        chk(o_irq, 1'b0, "irq cleared");
        rg(4'h2, 1'b1);
        rd(ADR_RGMII_STAT, 32'hd, 32'hf);
        for (i = 0; i < 3; i++) begin
            v = xs();
            s = {v[3], (v[2:1] == 2'h3) ? 2'h1 : v[2:1], v[0]};
            rg(s, 1'b0);
            rd(ADR_RGMII_STAT, {28'h0, s}, 32'hffff_ffff);
        end
        $display("test done: rgmii status");
        i_pll_lock <= 1'b1;
        i_optical_signal_present <= 1'b1;
        repeat (8) @(posedge i_clk_sys);
        rd(ADR_SGMII_STAT, 32'h30, 32'h30);
        i_optical_signal_present <= 1'b0;
        repeat (8) @(posedge i_clk_sys);
        rd(ADR_SGMII_STAT, 32'h10, 32'h30);
        wr(ADR_PORT_CTRL, {29'h0, MODE_SGMII});
        wr(ADR_LOCAL_ABIL, 32'h1401);
        rd(ADR_LOCAL_ABIL, 32'h1401, 32'hffff_ffff);
        wr(ADR_SGMII_CTRL, 32'h0);
        wr(ADR_SGMII_CTRL, 32'h1);
        an(16'h8800);
        rd(ADR_SGMII_STAT, 32'h6, 32'h6);
        chk({o_sgmii_speed, o_sgmii_duplex}, 3'h4, "follower speed");
        wr(ADR_SGMII_CTRL, 32'h21);
        chk({o_sgmii_speed, o_sgmii_duplex}, 3'h3, "lead speed");
        wr(ADR_SGMII_CTRL, 32'h0);
        wr(ADR_SGMII_CTRL, 32'h1);
        an(16'h9800);
        rd(ADR_SGMII_STAT, 32'h5, 32'h7);
        wr(ADR_PARTNER_ABL, 32'h0);
        rd(ADR_PARTNER_ABL, 32'h9800, 32'hffff_ffff);
        i_optical_signal_present <= 1'b1;
        wr(ADR_SGMII_CTRL, 32'h0);
        repeat (4) @(posedge i_clk_sys);
        rd(ADR_SGMII_STAT, 32'h21, 32'h23);
        i_optical_signal_present <= 1'b0;
        $display("test done: sgmii negotiation");
        wr(ADR_SGMII_CTRL, 32'h2);
        wr(ADR_SGMII_CTRL, 32'h3);
        an(16'h8020);
        an(16'h8000);
        rd(ADR_SGMII_STAT, 32'h8, 32'hc);
        wr(ADR_SGMII_CTRL, 32'hb);
        rd(ADR_SGMII_CTRL, 32'h3, 32'h7f);
        rd(ADR_SGMII_STAT, 32'h0, 32'h8);
        an(16'h0000);
        rd(ADR_SGMII_STAT, 32'h6, 32'h6);
        $display("test done: fiber next page");
        wr(ADR_SGMII_CTRL, 32'h41);
        for (i = 0; i < 6; i++) begin
            @(posedge i_clk_sys);
            if (i > 0) chk(o_tx_code, (c === K285_RDN) ? K285_RDP : K285_RDN, "k28.5 order");
            c = o_tx_code;
        end
        chk((c === K285_RDN) || (c === K285_RDP), 1'b1, "k28.5 code");
        wr(ADR_SGMII_CTRL, 32'h1);
        for (i = 0; i < 8; i++) begin
            @(posedge i_clk_sys);
            if (i >= 2) chk(o_tx_code, h[i-2], "encoder pass");
            v = xs();
            h[i] = v[9:0];
            i_tx_code <= v[9:0];
        end
        $display("test done: encoder");
        i_reset <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        rd(ADR_PORT_CTRL, 32'h2, 32'hffff_ffff);
        rd(ADR_SGMII_CTRL, 32'h1, 32'h7f);
        $display("test done: second reset");
        results();
    end
endmodule
